// File: insn_timing_defines.svh
/*
  constants for the instruction decode and cycle-timing block:
  opcode map, operand field positions and cycle counts.
  assumes a 24-bit program word, one instruction cycle per clock.
*/
// Behaviour
// - each single word is 24 bits whose 8-bit opcode picks the instruction type and whose rest holds operands.
// - exactly three opcodes span two program words and every other opcode spans one word.
// - a double-word instruction collects both consecutive words, 48 bits, before it issues.
// - the upper eight bits of the second word of a double-word instruction are zero.
// - a second word fetched on its own runs as a no-operation with no side effects.
// - a single-word instruction takes one cycle, or two with a no-operation cycle when its test is true or it moves the PC.
// - branch_always, indirect call or goto, table reads and writes and returns take two or three cycles.
// - a taken skip takes two cycles over a one-word instruction and three over a two-word instruction.
// - every double-word instruction completes in two cycles.
// - instructions fall into word or byte, bit, literal and control categories.
// - word or byte working-register forms carry base_source_reg, source_reg with modifier and dest_reg with modifier.
// - word or byte file-register forms carry file_reg_field and a bit choosing that register or working_reg_zero.
// - bit forms name a working or file register and a bit position from a literal or from base_source_reg.
// - literal moves load literal_field into the named working or file register.
// - literal arithmetic takes base_source_reg and a literal and names dest_reg only when it differs from the source.
// - control forms carry a program address or a table read and write mode.
`ifndef INSN_TIMING_DEFINES_SVH
`define INSN_TIMING_DEFINES_SVH

`define WORD_W      24
`define OPC_HI      23
`define OPC_LO      16
`define OPC_W       8
`define EXT_W       16

`define OPC_NOP     8'h00
`define OPC_DW_A    8'h01
`define OPC_DW_B    8'h02
`define OPC_DW_C    8'h03
`define CTL_CBR     4'h1
`define CTL_BRANCH  6'h08
`define CTL_CALLI   6'h09
`define CTL_GOTOI   6'h0A
`define CTL_TBL     4'h3
`define CTL_RET     6'h10
`define CTL_RETI    6'h11
`define CTL_SKIP    4'h5
`define OPC_FORM    5
`define OPC_BYTE    0

`define F_BASE      15:12
`define F_DMODE     11:10
`define F_DST       9:6
`define F_SMODE     5:4
`define F_SRC       3:0
`define F_FDEST     13
`define F_FILE      12:0
`define F_BITPOS    15:12
`define F_BIND      11
`define F_BFILE     10
`define F_BFADDR    9:0
`define F_LITMOV    15:4
`define F_LITARI    10:4
`define F_SAME      11
`define F_ADDR      15:0
`define F_TMODE     1:0

`define CYC_COND    2
`define CYC_BRANCH  2
`define CYC_IND     2
`define CYC_TBL     2
`define CYC_RET     3
`define CYC_DW      2
`define CYC_MIN     2
`define CYC_MAX     3

`endif

// File: insn_timing_pkg.sv
/*
  types for the instruction decode and cycle-timing block.
  assumes insn_timing_defines.svh is on the include path.
*/
`include "insn_timing_defines.svh"

package insn_timing_pkg;

  typedef enum logic [1:0] {
    CAT_CTL = 2'h0,
    CAT_WB  = 2'h1,
    CAT_BIT = 2'h2,
    CAT_LIT = 2'h3
  } category_t;

  typedef enum logic [3:0] {
    KIND_NOP   = 4'h0,
    KIND_PLAIN = 4'h1,
    KIND_COND  = 4'h2,
    KIND_SKIP  = 4'h3,
    KIND_BRANCH = 4'h4,
    KIND_IND   = 4'h5,
    KIND_TBL   = 4'h6,
    KIND_RET   = 4'h7,
    KIND_DW    = 4'h8
  } kind_t;

  typedef enum logic [2:0] {
    ST_FETCH = 3'h0,
    ST_DW2   = 3'h1,
    ST_NOPS  = 3'h3,
    ST_SKIP1 = 3'h2,
    ST_SKIP2 = 3'h6
  } seq_state_t;

  typedef struct packed {
    seq_state_t              state;
    logic [1:0]              cnt;
    logic                    issue;
    logic                    nop;
    logic                    dw;
    logic                    dw_fault;
    kind_t                   kind;
    category_t               cat;
    logic [`WORD_W-1:0]      word;
    logic [`EXT_W-1:0]       ext;
  } seq_t;

endpackage : insn_timing_pkg

// File: opcode_classifier.sv
/*
  opcode classifier: maps an 8-bit opcode to category, timing kind
  and the double-word flag. purely combinational.
  assumes the caller registers whatever it keeps.
*/
`timescale 1ns/1ps
`include "insn_timing_defines.svh"

module opcode_classifier (
  input  wire logic [`OPC_W-1:0]          i_opcode,
  output insn_timing_pkg::category_t      o_category,
  output insn_timing_pkg::kind_t          o_kind,
  output logic                            o_double
);

  logic [5:0] sub;

  always_comb begin
    sub        = i_opcode[5:0];
    o_category = insn_timing_pkg::category_t'(i_opcode[7:6]);
    o_kind     = insn_timing_pkg::KIND_PLAIN;
    o_double   = 1'b0;
    if (i_opcode == `OPC_NOP) begin
      o_kind = insn_timing_pkg::KIND_NOP;
    end else if (o_category == insn_timing_pkg::CAT_CTL) begin
      // only these three span two words
      if (i_opcode == `OPC_DW_A || i_opcode == `OPC_DW_B || i_opcode == `OPC_DW_C) begin
        o_kind   = insn_timing_pkg::KIND_DW;
        o_double = 1'b1;
      end else if (sub[5:2] == `CTL_CBR) begin
        o_kind = insn_timing_pkg::KIND_COND;
      end else if (sub == `CTL_BRANCH) begin
        o_kind = insn_timing_pkg::KIND_BRANCH;
      end else if (sub == `CTL_CALLI || sub == `CTL_GOTOI) begin
        o_kind = insn_timing_pkg::KIND_IND;
      end else if (sub[5:2] == `CTL_TBL) begin
        o_kind = insn_timing_pkg::KIND_TBL;
      end else if (sub == `CTL_RET || sub == `CTL_RETI) begin
        o_kind = insn_timing_pkg::KIND_RET;
      end else if (sub[5:2] == `CTL_SKIP) begin
        o_kind = insn_timing_pkg::KIND_SKIP;
      end
    end
  end

endmodule : opcode_classifier

// File: insn_decode_timing.sv
/*
  instruction decode and cycle-timing sequencer. takes program words
  on a valid/ready fetch port, pairs double words, issues one decoded
  instruction per cycle and inserts no-operation cycles.
  assumes the datapath returns the condition result combinationally
  in the issue cycle, and that the clock is the instruction clock.
*/
`timescale 1ns/1ps
`include "insn_timing_defines.svh"

module insn_decode_timing #(
  parameter int unsigned RET_CYCLES = `CYC_RET
) (
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_rst_b,
  input  wire logic                        i_fetch_valid,
  input  wire logic [`WORD_W-1:0]          i_fetch_word,
  input  wire logic                        i_cond_true,
  output logic                             o_fetch_ready,
  output logic                             o_exec_valid,
  output logic                             o_nop_cycle,
  output logic [`OPC_W-1:0]                o_opcode,
  output insn_timing_pkg::category_t       o_category,
  output insn_timing_pkg::kind_t           o_kind,
  output logic                             o_double,
  output logic                             o_dw_fault,
  output logic                             o_byte_op,
  output logic                             o_file_form,
  output logic [3:0]                       o_base_source_reg,
  output logic [3:0]                       o_source_reg,
  output logic [1:0]                       o_source_mode,
  output logic [3:0]                       o_dest_reg,
  output logic [1:0]                       o_dest_mode,
  output logic [12:0]                      o_file_reg_field,
  output logic                             o_dest_working_reg_zero,
  output logic [3:0]                       o_bit_pos,
  output logic                             o_bit_from_base,
  output logic [11:0]                      o_literal_field,
  output logic                             o_dest_is_source,
  output logic [15:0]                      o_prog_addr,
  output logic [1:0]                       o_table_mode,
  output logic [`EXT_W-1:0]                o_ext_word
);

  if ((RET_CYCLES < `CYC_MIN) || (RET_CYCLES > `CYC_MAX)) begin : g_ret_check
    $error("RET_CYCLES must be two or three");
  end

  insn_timing_pkg::seq_t       q;
  insn_timing_pkg::seq_t       d;
  insn_timing_pkg::category_t  cls_cat;
  insn_timing_pkg::kind_t      cls_kind;
  logic                        cls_double;
  logic [1:0]                  extra;
  logic                        need_nops;
  logic                        skip_go;
  logic                        discard;
  logic                        take;
  logic [`WORD_W-1:0]          w;

  // cycles beyond the issue cycle, as a down-count seed
  function automatic logic [1:0] extra_cycles(input insn_timing_pkg::kind_t k,
                                               input logic cond);
    logic [1:0] r;
    r = 2'h0;
    unique case (k)
      insn_timing_pkg::KIND_COND: r = cond ? 2'(`CYC_COND - 1) : 2'h0;
      insn_timing_pkg::KIND_BRANCH: r = 2'(`CYC_BRANCH - 1);
      insn_timing_pkg::KIND_IND:  r = 2'(`CYC_IND - 1);
      insn_timing_pkg::KIND_TBL:  r = 2'(`CYC_TBL - 1);
      insn_timing_pkg::KIND_RET:  r = 2'(RET_CYCLES - 1);
      // second-word fetch already was the first of the two cycles
      insn_timing_pkg::KIND_DW:   r = 2'(`CYC_DW - 2);
      insn_timing_pkg::KIND_NOP,
      insn_timing_pkg::KIND_PLAIN,
      insn_timing_pkg::KIND_SKIP: r = 2'h0;
      default:                    r = 2'h0;
    endcase
    return r;
  endfunction : extra_cycles

  opcode_classifier u_classifier (
    .i_opcode   (i_fetch_word[`OPC_HI:`OPC_LO]),
    .o_category (cls_cat),
    .o_kind     (cls_kind),
    .o_double   (cls_double)
  );

  always_comb begin
    extra     = extra_cycles(q.kind, i_cond_true);
    need_nops = q.issue && (extra != 2'h0);
    skip_go   = q.issue && (q.kind == insn_timing_pkg::KIND_SKIP) && i_cond_true;
    unique case (q.state)
      insn_timing_pkg::ST_FETCH: o_fetch_ready = !need_nops;
      insn_timing_pkg::ST_NOPS:  o_fetch_ready = (q.cnt == 2'h0);
      insn_timing_pkg::ST_DW2,
      insn_timing_pkg::ST_SKIP1,
      insn_timing_pkg::ST_SKIP2: o_fetch_ready = 1'b1;
      default:                   o_fetch_ready = 1'b0;
    endcase
    take    = i_fetch_valid && o_fetch_ready;
    discard = skip_go || (q.state == insn_timing_pkg::ST_SKIP1) ||
              (q.state == insn_timing_pkg::ST_SKIP2);
  end

  always_comb begin
    d          = q;
    d.issue    = 1'b0;
    d.nop      = 1'b0;
    d.dw_fault = 1'b0;
    unique case (q.state)
      insn_timing_pkg::ST_FETCH: begin
        if (need_nops) begin
          d.state = insn_timing_pkg::ST_NOPS;
          d.cnt   = extra - 2'h1;
          d.nop   = 1'b1;
        end else if (skip_go) begin
          // the word taken now is the skipped one
          if (take) begin
            d.nop   = 1'b1;
            d.state = cls_double ? insn_timing_pkg::ST_SKIP2 : insn_timing_pkg::ST_FETCH;
          end else begin
            d.state = insn_timing_pkg::ST_SKIP1;
          end
        end
      end
      insn_timing_pkg::ST_DW2: begin
        d.state = insn_timing_pkg::ST_DW2;
      end
      insn_timing_pkg::ST_NOPS: begin
        if (q.cnt != 2'h0) begin
          d.cnt = q.cnt - 2'h1;
          d.nop = 1'b1;
        end else begin
          d.state = insn_timing_pkg::ST_FETCH;
        end
      end
      insn_timing_pkg::ST_SKIP1: begin
        // fetch stalled during the skip; slack cycles add to its length
        if (take) begin
          d.nop   = 1'b1;
          d.state = cls_double ? insn_timing_pkg::ST_SKIP2 : insn_timing_pkg::ST_FETCH;
        end
      end
      insn_timing_pkg::ST_SKIP2: begin
        if (take) begin
          d.nop   = 1'b1;
          d.state = insn_timing_pkg::ST_FETCH;
        end
      end
      default: begin
        d.state = insn_timing_pkg::ST_FETCH;
      end
    endcase

    if (take && !discard) begin
      if (q.state == insn_timing_pkg::ST_DW2) begin
        // both words in hand: first word and low 16 bits of the second issue together
        d.ext      = i_fetch_word[`EXT_W-1:0];
        d.dw_fault = (i_fetch_word[`OPC_HI:`OPC_LO] != `OPC_NOP);
        d.issue    = 1'b1;
        d.state    = insn_timing_pkg::ST_FETCH;
      end else begin
        d.word = i_fetch_word;
        d.kind = cls_kind;
        d.cat  = cls_cat;
        d.dw   = cls_double;
        d.ext  = '0;
        if (cls_double) begin
          d.state = insn_timing_pkg::ST_DW2;
        end else begin
          d.issue = 1'b1;
          d.state = insn_timing_pkg::ST_FETCH;
        end
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign w = q.word;

  // fields are sliced for every form; o_category says which are live
  assign o_exec_valid            = q.issue;
  assign o_nop_cycle             = q.nop;
  assign o_opcode                = w[`OPC_HI:`OPC_LO];
  assign o_category              = q.cat;
  assign o_kind                  = q.kind;
  assign o_double                = q.dw;
  assign o_dw_fault              = q.dw_fault;
  assign o_byte_op               = w[`OPC_LO + `OPC_BYTE];
  assign o_file_form             = w[`OPC_LO + `OPC_FORM];
  assign o_base_source_reg       = w[`F_BASE];
  assign o_source_reg            = w[`F_SRC];
  assign o_source_mode           = w[`F_SMODE];
  assign o_dest_reg              = w[`F_DST];
  assign o_dest_mode             = w[`F_DMODE];
  assign o_file_reg_field        = (q.cat == insn_timing_pkg::CAT_BIT) ?
                                   {3'h0, w[`F_BFADDR]} : w[`F_FILE];
  assign o_dest_working_reg_zero = !w[`F_FDEST];
  assign o_bit_pos               = w[`F_BITPOS];
  assign o_bit_from_base         = w[`F_BIND];
  assign o_literal_field         = w[`OPC_LO + `OPC_FORM] ?
                                   {5'h00, w[`F_LITARI]} : w[`F_LITMOV];
  assign o_dest_is_source        = w[`F_SAME];
  assign o_prog_addr             = w[`F_ADDR];
  assign o_table_mode            = w[`F_TMODE];
  assign o_ext_word              = q.ext;

endmodule : insn_decode_timing

// File: insn_decode_timing_asserts.sv
/*
  checker for insn_decode_timing: issue timing, word pairing and opcode relations.
  assumes it is bound onto the top module, one instruction clock, reset low.
*/
`timescale 1ns/1ps

module insn_decode_timing_chk #(
  parameter int unsigned RET_CYCLES = 3
) (
  input  wire logic                       i_clk_sys,
  input  wire logic                       i_rst_b,
  input  wire logic                       i_fetch_valid,
  input  wire logic [23:0]                i_fetch_word,
  input  wire logic                       i_cond_true,
  input  wire logic                       o_fetch_ready,
  input  wire logic                       o_exec_valid,
  input  wire logic                       o_nop_cycle,
  input  wire logic [7:0]                 o_opcode,
  input  wire insn_timing_pkg::category_t o_category,
  input  wire insn_timing_pkg::kind_t     o_kind,
  input  wire logic                       o_double,
  input  wire logic                       o_dw_fault,
  input  wire logic [15:0]                o_ext_word
);
  logic [7:0]  fw_opc;
  logic [15:0] fw_low;
  assign fw_opc = i_fetch_word[23:16];
  assign fw_low = i_fetch_word[15:0];

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);

  property p_plain;
    o_exec_valid && o_kind == insn_timing_pkg::KIND_PLAIN |-> o_fetch_ready ##1 !o_nop_cycle;
  endproperty
  a_plain: assert property (p_plain) else $error("plain issue stalled");
  property p_branch;
    o_exec_valid && o_kind inside {insn_timing_pkg::KIND_BRANCH, insn_timing_pkg::KIND_IND, insn_timing_pkg::KIND_TBL}
      |-> !o_fetch_ready ##1 o_nop_cycle && o_fetch_ready;
  endproperty
  a_branch: assert property (p_branch) else $error("branch not two cycles");
  property p_cond;
    o_exec_valid && o_kind == insn_timing_pkg::KIND_COND
      |-> o_fetch_ready != i_cond_true ##1 o_nop_cycle == $past(i_cond_true);
  endproperty
  a_cond: assert property (p_cond) else $error("conditional timing wrong");
  property p_ret;
    o_exec_valid && o_kind == insn_timing_pkg::KIND_RET
      |-> !o_fetch_ready ##1 o_nop_cycle ##(RET_CYCLES-2) o_nop_cycle && o_fetch_ready;
  endproperty
  a_ret: assert property (p_ret) else $error("return timing wrong");
  property p_skip;
    o_exec_valid && o_kind == insn_timing_pkg::KIND_SKIP && i_cond_true |=> o_nop_cycle;
  endproperty
  a_skip: assert property (p_skip) else $error("taken skip without no-op");
  property p_dw_map;
    o_exec_valid |-> o_double == (o_opcode inside {8'h01, 8'h02, 8'h03});
  endproperty
  a_dw_map: assert property (p_dw_map) else $error("double flag wrong");
  property p_dw_take;
    o_exec_valid && o_double |-> $past(i_fetch_valid) && $past(o_fetch_ready) && o_ext_word == $past(fw_low);
  endproperty
  a_dw_take: assert property (p_dw_take) else $error("double issued before second word");
  property p_dw_fault;
    o_exec_valid && o_double |-> o_dw_fault == ($past(fw_opc) != 8'h00);
  endproperty
  a_dw_fault: assert property (p_dw_fault) else $error("second word flag wrong");
  property p_lone;
    o_exec_valid && o_opcode == 8'h00 |-> o_kind == insn_timing_pkg::KIND_NOP && !o_double;
  endproperty
  a_lone: assert property (p_lone) else $error("zero opcode not a no-op");
  property p_opc;
    o_exec_valid && !o_double |-> o_opcode == $past(fw_opc) && o_category == o_opcode[7:6];
  endproperty
  a_opc: assert property (p_opc) else $error("opcode or category wrong");
endmodule : insn_decode_timing_chk

bind insn_decode_timing insn_decode_timing_chk #(.RET_CYCLES(RET_CYCLES)) u_chk (
  .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_fetch_valid(i_fetch_valid), .i_fetch_word(i_fetch_word),
  .i_cond_true(i_cond_true), .o_fetch_ready(o_fetch_ready), .o_exec_valid(o_exec_valid),
  .o_nop_cycle(o_nop_cycle), .o_opcode(o_opcode), .o_category(o_category), .o_kind(o_kind),
  .o_double(o_double), .o_dw_fault(o_dw_fault), .o_ext_word(o_ext_word)
);

// File: prog_fetch_model.sv
/*
  program word source: offers queued words on a valid/ready port.
  assumes the bench loads it between runs, away from the rising edge.
*/
`timescale 1ns/1ps

module prog_fetch_model (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_b,
  input  wire logic        i_ready,
  output logic             o_valid,
  output logic [23:0]      o_word
);
  logic [24:0] q[$];  // bit 24 marks one idle cycle

  initial begin
    o_valid = 1'b0;
    o_word  = 24'h00_0000;
  end

  task automatic push(input logic [24:0] w);
    q.push_back(w);
  endtask : push

  function automatic logic busy();
    return o_valid || q.size() != 0;
  endfunction : busy

  // word held until taken; idle lines toggle so stale data never passes
  always @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_valid <= 1'b0;
    end else if (!o_valid || i_ready) begin
      o_valid <= q.size() != 0 && !q[0][24];
      o_word  <= (q.size() != 0 && !q[0][24]) ? q[0][23:0] : ~o_word;
      if (q.size() != 0) void'(q.pop_front());
    end
  end
endmodule : prog_fetch_model

// File: insn_decode_timing_tb.sv
/*
  testbench for insn_decode_timing: word streams through the fetch model, issue spacing and fields.
  assumes the checker is bound and the fetch model answers one word per cycle.
*/
`timescale 1ns/1ps

module insn_decode_timing_tb;
  localparam logic [24:0] PLN  = 25'h040_0000;
  localparam logic [24:0] HOLE = 25'h100_0000;
  logic                       i_clk_sys = 1'b0;
  logic                       i_rst_b = 1'b0;
  logic                       i_cond_true = 1'b0;
  logic                       i_fetch_valid, o_fetch_ready, o_exec_valid, o_nop_cycle, o_double, o_dw_fault;
  logic                       o_byte_op, o_file_form, o_dest_working_reg_zero, o_bit_from_base, o_dest_is_source;
  logic [23:0]                i_fetch_word;
  logic [7:0]                 o_opcode;
  insn_timing_pkg::category_t o_category;
  insn_timing_pkg::kind_t     o_kind;
  logic [3:0]                 o_base_source_reg, o_source_reg, o_dest_reg, o_bit_pos;
  logic [1:0]                 o_source_mode, o_dest_mode, o_table_mode;
  logic [12:0]                o_file_reg_field;
  logic [11:0]                o_literal_field;
  logic [15:0]                o_prog_addr, o_ext_word;
  int                         error_cnt = 0;
  int                         cmp_count = 0;
  int                         cyc = 0;
  int                         t_q[$];
  logic [3:0]                 k_q[$];
  logic [17:0]                d_q[$];

  insn_decode_timing u_dut (
    .i_clk_sys, .i_rst_b, .i_fetch_valid, .i_fetch_word, .i_cond_true, .o_fetch_ready, .o_exec_valid,
    .o_nop_cycle, .o_opcode, .o_category, .o_kind, .o_double, .o_dw_fault, .o_byte_op, .o_file_form,
    .o_base_source_reg, .o_source_reg, .o_source_mode, .o_dest_reg, .o_dest_mode, .o_file_reg_field,
    .o_dest_working_reg_zero, .o_bit_pos, .o_bit_from_base, .o_literal_field, .o_dest_is_source,
    .o_prog_addr, .o_table_mode, .o_ext_word
  );
  prog_fetch_model u_mem (
    .i_clk_sys, .i_rst_b, .i_ready(o_fetch_ready), .o_valid(i_fetch_valid), .o_word(i_fetch_word)
  );

  always #2 i_clk_sys = ~i_clk_sys;

  // issue log: cycle, kind and {fault, double, ext}
  always @(posedge i_clk_sys) begin
    cyc++;
    if (o_exec_valid === 1'b1) begin
      t_q.push_back(cyc);
      k_q.push_back(o_kind);
      d_q.push_back({o_dw_fault, o_double, o_ext_word});
    end
  end

  task automatic chk_val(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %0h seen %0h", n, e, g);
    end
  endtask : chk_val

  task automatic chk_gaps(input string n, input int e[$]);
    chk_val({n, " issues"}, e.size() + 1, t_q.size());
    foreach (e[i]) if (t_q.size() > i + 1) chk_val(n, e[i], t_q[i+1] - t_q[i]);
  endtask : chk_gaps

  task automatic play(input logic [24:0] w[$], input logic c);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    i_cond_true <= c;
    @(negedge i_clk_sys);
    t_q.delete();
    k_q.delete();
    d_q.delete();
    foreach (w[i]) u_mem.push(w[i]);
    while (u_mem.busy() && n < 100) begin
      @(posedge i_clk_sys);
      n++;
    end
    repeat (4) @(posedge i_clk_sys);
  endtask : play

  task automatic s_timing;
    play('{PLN, 25'h008_0000, PLN, 25'h010_0000, PLN, 25'h011_0000, PLN, 25'h00C_0000, PLN,
           25'h009_0000, PLN, 25'h00A_0000, PLN}, 1'b0);
    chk_gaps("timing", '{1, 2, 1, 3, 1, 3, 1, 2, 1, 2, 1, 2});
  endtask : s_timing

  task automatic s_cond_skip;
    play('{25'h004_0000, PLN}, 1'b1);
    chk_gaps("cond true", '{2});
    play('{25'h004_0000, PLN, 25'h014_0000, PLN}, 1'b0);
    chk_gaps("untaken", '{1, 1, 1});
    play('{25'h014_0000, 25'h008_0000, PLN}, 1'b1);
    chk_gaps("skip one", '{2});
    play('{25'h014_0000, 25'h001_0000, 25'h000_1234, PLN}, 1'b1);
    chk_gaps("skip two", '{3});
  endtask : s_cond_skip

  task automatic s_double;
    logic [17:0] e[5] = '{18'h0_0000, 18'h1_1234, 18'h1_5678, 18'h3_9ABC, 18'h0_0000};
    play('{PLN, 25'h001_0000, 25'h000_1234, 25'h002_0000, HOLE, 25'h000_5678, 25'h003_0000,
           25'h012_9ABC, PLN}, 1'b0);
    chk_gaps("double", '{2, 3, 2, 1});
    foreach (e[i]) chk_val("double word", e[i], d_q[i]);
    play('{25'h000_1234}, 1'b0);
    chk_val("lone kind", insn_timing_pkg::KIND_NOP, k_q[0]);
  endtask : s_double

  task automatic s_fields;
    play('{25'h040_A6E5}, 1'b0);
    chk_val("category", 2'h1, o_category);
    chk_val("base", 4'hA, o_base_source_reg);
    chk_val("source", 4'h5, o_source_reg);
    chk_val("dest", 4'hB, o_dest_reg);
    chk_val("source mode", 2'h2, o_source_mode);
    chk_val("dest mode", 2'h1, o_dest_mode);
    chk_val("byte op", 1'b0, o_byte_op);
    chk_val("file form", 1'b0, o_file_form);
    play('{25'h061_2ABC}, 1'b0);
    chk_val("file", 13'h0ABC, o_file_reg_field);
    chk_val("dest zero", 1'b0, o_dest_working_reg_zero);
    chk_val("byte op", 1'b1, o_byte_op);
    chk_val("file form", 1'b1, o_file_form);
    play('{25'h080_7C00}, 1'b0);
    chk_val("bit pos", 4'h7, o_bit_pos);
    chk_val("bit from base", 1'b1, o_bit_from_base);
    play('{25'h0C0_1234}, 1'b0);
    chk_val("literal", 12'h123, o_literal_field);
    play('{25'h0E0_0FF0}, 1'b0);
    chk_val("short literal", 12'h07F, o_literal_field);
    chk_val("same dest", 1'b1, o_dest_is_source);
    play('{25'h008_BEEF}, 1'b0);
    chk_val("address", 16'hBEEF, o_prog_addr);
    play('{25'h00C_0002}, 1'b0);
    chk_val("table mode", 2'h2, o_table_mode);
  endtask : s_fields

  task automatic test_done;
    $display("mismatches %0d comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  initial begin
    repeat (12) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    s_timing();
    s_cond_skip();
    s_double();
    s_fields();
    test_done();
  end

  // runs need well under 1000 cycles; this cuts a hang
  initial begin
    repeat (4000) @(posedge i_clk_sys);
    error_cnt++;
    test_done();
  end
endmodule : insn_decode_timing_tb
